//--- inc/port_event_pkg.sv
package port_event_pkg;

    // ------------------------------------------------------------
    // banks and register numbers
    // ------------------------------------------------------------
    localparam logic [4:0] BANK_STATUS = 5'h01;
    localparam logic [4:0] BANK_CONTROL = 5'h02;
    localparam logic [4:0] BANK_RESET = 5'h00;
    localparam logic [4:0] REG_RESET = 5'h00;

    localparam logic [4:0] REG_TP_PARTITION = 5'h00;
    localparam logic [4:0] REG_AUI_PARTITION = 5'h01;
    localparam logic [4:0] REG_TP_LINK = 5'h02;
    localparam logic [4:0] REG_AUI_LOOPBACK = 5'h03;
    localparam logic [4:0] REG_AUI_SQE = 5'h05;
    localparam logic [4:0] REG_TP_SRC_CHANGE = 5'h06;
    localparam logic [4:0] REG_AUI_SRC_CHANGE = 5'h07;
    localparam logic [4:0] REG_TP_SRC_MATCH = 5'h08;
    localparam logic [4:0] REG_AUI_SRC_MATCH = 5'h09;

    // ------------------------------------------------------------
    // command byte layout and field positions
    // ------------------------------------------------------------
    localparam int CMD_REG_SELECT_BIT = 7;
    localparam int AUI_FLAG_BIT = 7;
    localparam int AUI_PORT_INDEX = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int TP_PORT_COUNT = 8;
    localparam int SRC_ADDR_WIDTH = 48;

endpackage

//--- hdl/port_event_status_irq.sv
`timescale 1ns/1ns

// Notes on behaviour
// R1: partition entry or exit sets port flag
// R2: status registers read-only, cleared by read
// R3: aui status only top bit carries flag
// R4: tp link pass/fail change sets bit
// R5: aui loopback failure sets loopback error flag
// R6: loopback and sqe invalid on older repeater
// R7: loopback flag re-sets on next transmission
// R8: sqe test seen sets flag, every packet
// R9: source address change sets tp/aui bit
// R10: first frame per port flags address change
// R11: source address match sets receiving port bit
// R12: bank two selects read/write control registers
// R13: control bit one enables; reset clears all
// R14: hardware reset disables irqs, clears status
// R15: clearing enable drops interrupt output immediately
// R16: partition enables: tp byte, aui top bit
// R17: host writes zero to aui reserved bits
// R18: link enable with status drives interrupt
// R19: loopback enable interrupts on each error
// R20: sqe enable interrupts on each error
// R21: source change enables: tp byte, aui bit
// R22: unwritten last address taken from first frame
// R23: host may preload last source address
// R24: global enable off masks, output undriven
// R25: interrupt when status, enable, global set
// R26: event during read-clear stays set
module port_event_status_irq
    import port_event_pkg::*;
#(
    parameter int TP_PORTS = TP_PORT_COUNT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hostSelData,
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [7:0] hostWrData,
    output logic [7:0] hostRdData,
    input wire logic [7:0] tpPartitioned,
    input wire logic auiPartitioned,
    input wire logic [7:0] tpLinkPass,
    input wire logic auiLoopbackFail,
    input wire logic auiSqeSeen,
    input wire logic repeaterIsPlus,
    input wire logic frameValid,
    input wire logic [3:0] framePort,
    input wire logic [SRC_ADDR_WIDTH-1:0] frameSrcAddr,
    input wire logic [SRC_ADDR_WIDTH-1:0] matchAddr,
    input wire logic lastSrcAddrLoad,
    input wire logic [3:0] lastSrcAddrPort,
    input wire logic [SRC_ADDR_WIDTH-1:0] lastSrcAddrValue,
    input wire logic irqGlobalEnable,
    input wire logic srcMatchIrqEnable,
    output logic intOutN,
    output logic intOe
);

    generate
        if (TP_PORTS != TP_PORT_COUNT)
        begin : g_check
            $error("tp port count must be eight");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] bank;
        logic [4:0] regSel;
        logic primed;
        logic [8:0] partPrev;
        logic [7:0] linkPrev;
        logic [8:0] partChg;
        logic [7:0] linkChg;
        logic loopErr;
        logic sqeErr;
        logic [8:0] srcChg;
        logic [8:0] srcMatch;
        logic [8:0] partEn;
        logic [7:0] linkEn;
        logic loopEn;
        logic sqeEn;
        logic [8:0] srcChgEn;
        logic [8:0] lsaKnown;
        logic [8:0][SRC_ADDR_WIDTH-1:0] lastSrcAddr;
        logic [7:0] rdData;
        logic intOutN;
        logic intOe;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] auiByte(input logic flag);
        auiByte = {flag, 7'h00};
    endfunction

    function automatic logic [7:0] statusByte(input state_s st, input logic [4:0] r, input logic plus);
        logic [7:0] b;
        b = UNMAPPED_READ;
        if (r == REG_TP_PARTITION)
            b = st.partChg[7:0];
        else if (r == REG_AUI_PARTITION)
            b = auiByte(st.partChg[AUI_PORT_INDEX]); // [R3]
        else if (r == REG_TP_LINK)
            b = st.linkChg;
        else if (r == REG_AUI_LOOPBACK)
            b = plus ? auiByte(st.loopErr) : UNMAPPED_READ; // [R6]
        else if (r == REG_AUI_SQE)
            b = plus ? auiByte(st.sqeErr) : UNMAPPED_READ; // [R6]
        else if (r == REG_TP_SRC_CHANGE)
            b = st.srcChg[7:0];
        else if (r == REG_AUI_SRC_CHANGE)
            b = auiByte(st.srcChg[AUI_PORT_INDEX]);
        else if (r == REG_TP_SRC_MATCH)
            b = st.srcMatch[7:0];
        else if (r == REG_AUI_SRC_MATCH)
            b = auiByte(st.srcMatch[AUI_PORT_INDEX]);
        statusByte = b;
    endfunction

    function automatic logic [7:0] controlByte(input state_s st, input logic [4:0] r);
        logic [7:0] b;
        b = UNMAPPED_READ;
        if (r == REG_TP_PARTITION)
            b = st.partEn[7:0];
        else if (r == REG_AUI_PARTITION)
            b = auiByte(st.partEn[AUI_PORT_INDEX]);
        else if (r == REG_TP_LINK)
            b = st.linkEn;
        else if (r == REG_AUI_LOOPBACK)
            b = auiByte(st.loopEn);
        else if (r == REG_AUI_SQE)
            b = auiByte(st.sqeEn);
        else if (r == REG_TP_SRC_CHANGE)
            b = st.srcChgEn[7:0];
        else if (r == REG_AUI_SRC_CHANGE)
            b = auiByte(st.srcChgEn[AUI_PORT_INDEX]);
        controlByte = b;
    endfunction

    function automatic logic pending(input state_s st, input logic matchEn);
        pending = |(st.partChg & st.partEn) | |(st.linkChg & st.linkEn) // [R16] [R18] [R21]
            | (st.loopErr & st.loopEn) | (st.sqeErr & st.sqeEn) // [R19] [R20]
            | |(st.srcChg & st.srcChgEn) | (|st.srcMatch & matchEn);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [8:0] partNow;
    logic [8:0] partEvt;
    logic [7:0] linkEvt;
    logic [8:0] srcChgEvt;
    logic [8:0] srcMatchEvt;
    logic loopEvt;
    logic sqeEvt;
    logic statusRead;
    logic controlWrite;

    always_comb
    begin
        s_nxt = s_r;
        partNow = {auiPartitioned, tpPartitioned};
        partEvt = {9{s_r.primed}} & (partNow ^ s_r.partPrev); // [R1]
        linkEvt = {8{s_r.primed}} & (tpLinkPass ^ s_r.linkPrev); // [R4]
        loopEvt = auiLoopbackFail & repeaterIsPlus; // [R5] [R7]
        sqeEvt = auiSqeSeen & repeaterIsPlus; // [R8]
        srcChgEvt = 9'h000;
        srcMatchEvt = 9'h000;
        s_nxt.primed = 1'b1;
        s_nxt.partPrev = partNow;
        s_nxt.linkPrev = tpLinkPass;

        if (lastSrcAddrLoad && lastSrcAddrPort <= 4'(AUI_PORT_INDEX))
        begin
            s_nxt.lastSrcAddr[lastSrcAddrPort] = lastSrcAddrValue; // [R23]
            s_nxt.lsaKnown[lastSrcAddrPort] = 1'b1;
        end
        if (frameValid && framePort <= 4'(AUI_PORT_INDEX))
        begin
            srcChgEvt[framePort] = !s_r.lsaKnown[framePort]
                || s_r.lastSrcAddr[framePort] != frameSrcAddr; // [R9] [R10]
            srcMatchEvt[framePort] = frameSrcAddr == matchAddr; // [R11]
            s_nxt.lastSrcAddr[framePort] = frameSrcAddr; // [R22]
            s_nxt.lsaKnown[framePort] = 1'b1;
        end

        if (hostWr && !hostSelData)
        begin
            if (hostWrData[CMD_REG_SELECT_BIT])
                s_nxt.regSel = hostWrData[4:0];
            else
                s_nxt.bank = hostWrData[4:0];
        end

        controlWrite = hostWr && hostSelData && s_r.bank == BANK_CONTROL; // [R12]
        if (controlWrite)
        begin
            if (s_r.regSel == REG_TP_PARTITION)
                s_nxt.partEn[7:0] = hostWrData;
            else if (s_r.regSel == REG_AUI_PARTITION)
                s_nxt.partEn[AUI_PORT_INDEX] = hostWrData[AUI_FLAG_BIT]; // [R16] [R17]
            else if (s_r.regSel == REG_TP_LINK)
                s_nxt.linkEn = hostWrData;
            else if (s_r.regSel == REG_AUI_LOOPBACK)
                s_nxt.loopEn = hostWrData[AUI_FLAG_BIT];
            else if (s_r.regSel == REG_AUI_SQE)
                s_nxt.sqeEn = hostWrData[AUI_FLAG_BIT];
            else if (s_r.regSel == REG_TP_SRC_CHANGE)
                s_nxt.srcChgEn[7:0] = hostWrData;
            else if (s_r.regSel == REG_AUI_SRC_CHANGE)
                s_nxt.srcChgEn[AUI_PORT_INDEX] = hostWrData[AUI_FLAG_BIT]; // [R21]
        end

        statusRead = hostRd && hostSelData && s_r.bank == BANK_STATUS;
        if (hostRd && hostSelData)
        begin
            if (s_r.bank == BANK_STATUS)
                s_nxt.rdData = statusByte(s_r, s_r.regSel, repeaterIsPlus);
            else if (s_r.bank == BANK_CONTROL)
                s_nxt.rdData = controlByte(s_r, s_r.regSel);
            else
                s_nxt.rdData = UNMAPPED_READ;
        end
        if (statusRead)
        begin
            if (s_r.regSel == REG_TP_PARTITION)
                s_nxt.partChg[7:0] = STATUS_RESET; // [R2]
            else if (s_r.regSel == REG_AUI_PARTITION)
                s_nxt.partChg[AUI_PORT_INDEX] = 1'b0;
            else if (s_r.regSel == REG_TP_LINK)
                s_nxt.linkChg = STATUS_RESET;
            else if (s_r.regSel == REG_AUI_LOOPBACK)
                s_nxt.loopErr = 1'b0;
            else if (s_r.regSel == REG_AUI_SQE)
                s_nxt.sqeErr = 1'b0;
            else if (s_r.regSel == REG_TP_SRC_CHANGE)
                s_nxt.srcChg[7:0] = STATUS_RESET;
            else if (s_r.regSel == REG_AUI_SRC_CHANGE)
                s_nxt.srcChg[AUI_PORT_INDEX] = 1'b0;
            else if (s_r.regSel == REG_TP_SRC_MATCH)
                s_nxt.srcMatch[7:0] = STATUS_RESET;
            else if (s_r.regSel == REG_AUI_SRC_MATCH)
                s_nxt.srcMatch[AUI_PORT_INDEX] = 1'b0;
        end

        // set after clear so a same-cycle event survives
        s_nxt.partChg = s_nxt.partChg | partEvt; // [R26]
        s_nxt.linkChg = s_nxt.linkChg | linkEvt;
        s_nxt.loopErr = s_nxt.loopErr | loopEvt;
        s_nxt.sqeErr = s_nxt.sqeErr | sqeEvt;
        s_nxt.srcChg = s_nxt.srcChg | srcChgEvt;
        s_nxt.srcMatch = s_nxt.srcMatch | srcMatchEvt;

        s_nxt.intOutN = !(irqGlobalEnable && pending(s_nxt, srcMatchIrqEnable)); // [R25] [R15]
        s_nxt.intOe = irqGlobalEnable; // [R24]
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0; // [R13] [R14]
            s_r.bank <= BANK_RESET;
            s_r.regSel <= REG_RESET;
            s_r.rdData <= UNMAPPED_READ;
            s_r.intOutN <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign hostRdData = s_r.rdData;
    assign intOutN = s_r.intOutN;
    assign intOe = s_r.intOe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_partition_edge;
        s_r.primed && tpPartitioned[3] != $past(tpPartitioned[3]) |=> s_r.partChg[3];
    endproperty
    a_partition_edge: assert property (p_partition_edge) else $error("partition edge not flagged"); // [R1]

    property p_read_clears;
        hostRd && hostSelData && s_r.bank == BANK_STATUS && s_r.regSel == REG_TP_LINK
            && $stable(tpLinkPass) ##1 $stable(tpLinkPass) |-> s_r.linkChg == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("link status not cleared by read"); // [R2]

    property p_aui_reserved;
        $rose(hostRd) ##0 hostSelData && s_r.bank == BANK_STATUS && s_r.regSel == REG_AUI_PARTITION
            |=> hostRdData[6:0] == 7'h00;
    endproperty
    a_aui_reserved: assert property (p_aui_reserved) else $error("aui reserved bits not zero"); // [R3]

    property p_old_repeater;
        !repeaterIsPlus && !$past(repeaterIsPlus) && auiLoopbackFail && !s_r.loopErr |=> !s_r.loopErr;
    endproperty
    a_old_repeater: assert property (p_old_repeater) else $error("loopback set on old repeater"); // [R6]

    property p_sqe_set;
        auiSqeSeen && repeaterIsPlus |=> s_r.sqeErr;
    endproperty
    a_sqe_set: assert property (p_sqe_set) else $error("sqe flag not set"); // [R8]

    property p_first_frame;
        frameValid && framePort == 4'h2 && !s_r.lsaKnown[2] |=> s_r.srcChg[2] && s_r.lsaKnown[2];
    endproperty
    a_first_frame: assert property (p_first_frame) else $error("first frame not flagged"); // [R10]

    property p_match;
        frameValid && framePort == 4'h8 && frameSrcAddr == matchAddr |=> s_r.srcMatch[AUI_PORT_INDEX];
    endproperty
    a_match: assert property (p_match) else $error("aui match not flagged"); // [R11]

    property p_disable_drops;
        controlWrite && s_r.regSel == REG_TP_LINK && hostWrData == 8'h00 && s_r.partChg == 9'h000
            && !s_r.loopErr && !s_r.sqeErr && s_r.srcChg == 9'h000 && s_r.srcMatch == 9'h000
            && !frameValid && !auiLoopbackFail && !auiSqeSeen && partNow == s_r.partPrev |=> intOutN;
    endproperty
    a_disable_drops: assert property (p_disable_drops) else $error("interrupt held after disable"); // [R15]

    property p_global_off;
        !irqGlobalEnable |=> !intOe && intOutN;
    endproperty
    a_global_off: assert property (p_global_off) else $error("interrupt driven while disabled"); // [R24]

    property p_event_survives_read;
        hostRd && hostSelData && s_r.bank == BANK_STATUS && s_r.regSel == REG_TP_LINK
            && s_r.primed && tpLinkPass[4] != $past(tpLinkPass[4]) |=> s_r.linkChg[4];
    endproperty
    a_event_survives_read: assert property (p_event_survives_read) else $error("event lost on read"); // [R26]

    c_irq_asserted: cover property (irqGlobalEnable ##1 !intOutN);
    c_read_clear: cover property (hostRd && hostSelData && s_r.bank == BANK_STATUS ##1 hostRdData != 8'h00);
    c_src_change: cover property (frameValid && s_r.lsaKnown[2] && framePort == 4'h2 ##1 s_r.srcChg[2]);
    c_loop_repeat: cover property (s_r.loopErr && s_r.loopEn ##1 !s_r.loopErr ##[1:20] s_r.loopErr);

endmodule

//--- verification/host_port_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// host on the command and data ports
// ------------------------------------------------------------
module host_port_model
(
    input wire logic clock,
    input wire logic [7:0] hostRdData,
    output logic hostSelData,
    output logic hostWr,
    output logic hostRd,
    output logic [7:0] hostWrData
);
    initial
    begin
        hostSelData = 1'b0;
        hostWr = 1'b0;
        hostRd = 1'b0;
        hostWrData = 8'h00;
    end

    // one strobe per byte; released bus shows inverted data
    task automatic put(input logic toData, input logic [7:0] b);
        @(negedge clock);
        hostSelData = toData;
        hostWrData = b;
        hostWr = 1'b1;
        @(negedge clock);
        hostWr = 1'b0;
        hostWrData = ~b;
    endtask

    task automatic sel(input logic [4:0] bank, input logic [4:0] r);
        put(1'b0, {3'h0, bank});
        put(1'b0, {3'h4, r});
    endtask

    // aui registers get zeros in reserved bits
    task automatic wrReg(input logic [4:0] bank, input logic [4:0] r, input logic [7:0] b);
        sel(bank, r);
        put(1'b1, r[0] ? {b[7], 7'h00} : b);
    endtask

    task automatic rdData(output logic [7:0] b);
        @(negedge clock);
        hostSelData = 1'b1;
        hostRd = 1'b1;
        @(negedge clock);
        hostRd = 1'b0;
        b = hostRdData;
    endtask

    task automatic rdReg(input logic [4:0] bank, input logic [4:0] r, output logic [7:0] b);
        sel(bank, r);
        rdData(b);
    endtask
endmodule

//--- verification/port_event_status_irq_tb_top.sv
`timescale 1ns/1ns

module port_event_status_irq_tb_top
    import port_event_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hostSelData, hostWr, hostRd, intOutN, intOe;
    logic [7:0] hostWrData, hostRdData;
    logic [7:0] tpPartitioned = 8'h00;
    logic auiPartitioned = 1'b0;
    logic [7:0] tpLinkPass = 8'h00;
    logic auiLoopbackFail = 1'b0;
    logic auiSqeSeen = 1'b0;
    logic repeaterIsPlus = 1'b0;
    logic frameValid = 1'b0;
    logic [3:0] framePort = 4'h0;
    logic [47:0] frameSrcAddr = 48'h0;
    logic lastSrcAddrLoad = 1'b0;
    logic [3:0] lastSrcAddrPort = 4'h0;
    logic [47:0] lastSrcAddrValue = 48'h0;
    logic irqGlobalEnable = 1'b0;
    logic srcMatchIrqEnable = 1'b0;
    logic [4:0] ctrlRegs [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07};
    logic [7:0] enVal [7] = '{8'h04, 8'h80, 8'h02, 8'h80, 8'h80, 8'h10, 8'h80};
    logic [7:0] rb;
    int errCount = 0;
    int checksDone = 0;
    localparam logic [47:0] ADDR_M = 48'h02aa55aa55a1;

    initial
    begin
        forever #5 clock = ~clock;
    end

    port_event_status_irq i_port_event_status_irq (.clock(clock), .rst(rst), .hostSelData(hostSelData),
        .hostWr(hostWr), .hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData),
        .tpPartitioned(tpPartitioned), .auiPartitioned(auiPartitioned), .tpLinkPass(tpLinkPass),
        .auiLoopbackFail(auiLoopbackFail), .auiSqeSeen(auiSqeSeen), .repeaterIsPlus(repeaterIsPlus),
        .frameValid(frameValid), .framePort(framePort), .frameSrcAddr(frameSrcAddr), .matchAddr(ADDR_M),
        .lastSrcAddrLoad(lastSrcAddrLoad), .lastSrcAddrPort(lastSrcAddrPort),
        .lastSrcAddrValue(lastSrcAddrValue), .irqGlobalEnable(irqGlobalEnable),
        .srcMatchIrqEnable(srcMatchIrqEnable), .intOutN(intOutN), .intOe(intOe));

    host_port_model i_host_port_model (.clock(clock), .hostRdData(hostRdData), .hostSelData(hostSelData),
        .hostWr(hostWr), .hostRd(hostRd), .hostWrData(hostWrData));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic testDone();
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic expReg(input logic [4:0] bank, input logic [4:0] r, input logic [7:0] e);
        logic [7:0] b;
        i_host_port_model.rdReg(bank, r, b);
        chk(b, e);
    endtask

    task automatic intIs(input logic v);
        chk({7'h00, intOutN}, {7'h00, v});
    endtask

    task automatic frame(input logic [3:0] p, input logic [47:0] a);
        @(negedge clock);
        framePort = p;
        frameSrcAddr = a;
        frameValid = 1'b1;
        @(negedge clock);
        frameValid = 1'b0;
        frameSrcAddr = ~a;
    endtask

    task automatic aui(input logic lb, input logic sq);
        @(negedge clock);
        auiLoopbackFail = lb;
        auiSqeSeen = sq;
        @(negedge clock);
        auiLoopbackFail = 1'b0;
        auiSqeSeen = 1'b0;
        tick(1);
    endtask

    task automatic fire(input int i);
        case (i)
            0: tpPartitioned ^= 8'h04;
            1: auiPartitioned ^= 1'b1;
            2: tpLinkPass ^= 8'h02;
            3: aui(1'b1, 1'b0);
            4: aui(1'b0, 1'b1);
            5: frame(4'h4, 48'h0d0d0d0d0d0d);
            default: frame(4'h8, 48'h0d0d0d0d0d0d);
        endcase
        tick(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic tRegisters();
        for (int i = 0; i < 7; i++)
            expReg(BANK_CONTROL, ctrlRegs[i], CONTROL_RESET);
        for (int r = 0; r < 10; r++)
            expReg(BANK_STATUS, r[4:0], STATUS_RESET);
        for (int i = 0; i < 7; i++)
        begin
            i_host_port_model.wrReg(BANK_CONTROL, ctrlRegs[i], 8'ha5);
            expReg(BANK_CONTROL, ctrlRegs[i], ctrlRegs[i][0] ? 8'h80 : 8'ha5);
            i_host_port_model.wrReg(BANK_CONTROL, ctrlRegs[i], 8'h00);
        end
        i_host_port_model.wrReg(BANK_STATUS, 5'h00, 8'hff);
        expReg(BANK_STATUS, 5'h00, 8'h00);
        expReg(5'h03, 5'h00, UNMAPPED_READ);
        intIs(1'b1);
        chk({7'h00, intOe}, 8'h00);
    endtask

    task automatic tStatus();
        tpPartitioned = 8'h08;
        auiPartitioned = 1'b1;
        tpLinkPass = 8'h81;
        tick(2);
        expReg(BANK_STATUS, 5'h00, 8'h08);
        expReg(BANK_STATUS, 5'h00, 8'h00);
        expReg(BANK_STATUS, 5'h01, 8'h80);
        expReg(BANK_STATUS, 5'h02, 8'h81);
        tpPartitioned = 8'h00;
        tick(2);
        expReg(BANK_STATUS, 5'h00, 8'h08);
        aui(1'b1, 1'b1);
        expReg(BANK_STATUS, 5'h03, 8'h00);
        expReg(BANK_STATUS, 5'h05, 8'h00);
        repeaterIsPlus = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            aui(1'b1, 1'b1);
            expReg(BANK_STATUS, 5'h03, 8'h80);
            expReg(BANK_STATUS, 5'h05, 8'h80);
        end
    endtask

    task automatic tSource();
        frame(4'h2, 48'h0a0000000001);
        expReg(BANK_STATUS, 5'h06, 8'h04);
        frame(4'h2, 48'h0a0000000001);
        expReg(BANK_STATUS, 5'h06, 8'h00);
        frame(4'h2, 48'h0a0000000002);
        frame(4'h8, 48'h0a0000000002);
        expReg(BANK_STATUS, 5'h06, 8'h04);
        expReg(BANK_STATUS, 5'h07, 8'h80);
        @(negedge clock);
        lastSrcAddrPort = 4'h5;
        lastSrcAddrValue = 48'h0c0000000005;
        lastSrcAddrLoad = 1'b1;
        @(negedge clock);
        lastSrcAddrLoad = 1'b0;
        frame(4'h5, 48'h0c0000000005);
        expReg(BANK_STATUS, 5'h06, 8'h00);
        frame(4'h1, ADDR_M);
        frame(4'h8, ADDR_M);
        expReg(BANK_STATUS, 5'h08, 8'h02);
        expReg(BANK_STATUS, 5'h09, 8'h80);
        expReg(BANK_STATUS, 5'h06, 8'h02);
        expReg(BANK_STATUS, 5'h07, 8'h80);
    endtask

    task automatic tIrq();
        irqGlobalEnable = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            i_host_port_model.wrReg(BANK_CONTROL, ctrlRegs[i], enVal[i]);
            tick(1);
            intIs(1'b1);
            fire(i);
            intIs(1'b0);
            expReg(BANK_STATUS, ctrlRegs[i], enVal[i]);
            tick(1);
            intIs(1'b1);
        end
        fire(2);
        irqGlobalEnable = 1'b0;
        tick(2);
        chk({7'h00, intOe}, 8'h00);
        irqGlobalEnable = 1'b1;
        tick(2);
        chk({intOe, 6'h00, intOutN}, 8'h80);
        i_host_port_model.wrReg(BANK_CONTROL, 5'h02, 8'h00);
        tick(1);
        intIs(1'b1);
        expReg(BANK_STATUS, 5'h02, 8'h02);
        srcMatchIrqEnable = 1'b1;
        frame(4'h3, ADDR_M);
        tick(1);
        intIs(1'b0);
        expReg(BANK_STATUS, 5'h08, 8'h08);
        expReg(BANK_STATUS, 5'h06, 8'h08);
        tick(1);
        intIs(1'b1);
    endtask

    task automatic tEdges();
        i_host_port_model.sel(BANK_STATUS, 5'h02);
        fork
            i_host_port_model.rdData(rb);
            begin
                @(negedge clock);
                tpLinkPass ^= 8'h10;
            end
        join
        expReg(BANK_STATUS, 5'h02, 8'h10);
        i_host_port_model.wrReg(BANK_CONTROL, 5'h02, 8'hff);
        fire(2);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        intIs(1'b1);
        expReg(BANK_CONTROL, 5'h02, CONTROL_RESET);
        expReg(BANK_STATUS, 5'h02, STATUS_RESET);
    endtask

    // ------------------------------------------------------------
    // main sequence and hang limit
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        tick(1);
        tRegisters();
        tStatus();
        tSource();
        tIrq();
        tEdges();
        testDone();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errCount++;
        testDone();
    end
endmodule
